// [hdl/adcs_sequencer.sv]
module adcs_sequencer
    import adcs_pkg::*;
(
    // clock, reset, enable
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 clk_en,
    // axi4-lite write address
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // straps and clocks
    input  wire logic                 portb_analog_reset_cfg,
    input  wire logic                 internal_rc_conv_clk,
    // analog front end
    input  wire logic [RES_W-1:0]     sar_bit_result,
    input  wire logic [NUM_AN-1:0]    port_pins,
    output adcs_front_s               front,
    output logic                      hold_capacitor_connect,
    output logic                      conv_done_irq_flag
);

    adcs_ctrl0_s              ctrl0;
    adcs_ctrl2_s              ctrl2;
    logic [PORT_ANALOG_CFG_FIELD_W-1:0]        port_analog_cfg_field;
    logic [VCFG_W-1:0]        vref_cfg;
    logic [RES_W-1:0]         result_pair;
    adcs_state_e              state;
    logic [PERIOD_W-1:0]      div_cnt;
    logic [TAD_CNT_W-1:0]     tad_cnt;
    logic [2:0]               tcy_cnt;
    logic                     tad_tick;
    logic [2:0]               rc_sync;
    logic                     rc_level;
    logic [NUM_AN-1:0]        pin_s1;
    logic [NUM_AN-1:0]        pin_s2;
    logic [NUM_AN-1:0]        pin_s3;
    logic [NUM_AN-1:0]        pin_level;
    logic                     strap_taken;
    logic                     wr_fire;
    logic                     aw_held;
    logic                     w_held;
    logic [7:0]               wr_addr;
    logic [31:0]              wr_data;
    logic [3:0]               wr_strb;
    logic                     go_wr_set;
    logic                     go_wr_clr;
    logic [NUM_AN-1:0]        analog_mask;

    // conversion period in oscillator clocks, zero for rc source
    function automatic logic [PERIOD_W:0] period_of(input logic [2:0] sel);
        case (sel)
            3'b000:  period_of = 7'h02;
            3'b100:  period_of = 7'h04;
            3'b001:  period_of = 7'h08;
            3'b101:  period_of = 7'h10;
            3'b010:  period_of = 7'h20;
            3'b110:  period_of = 7'h40;
            default: period_of = 7'h00;
        endcase
    endfunction

    function automatic logic [TAD_CNT_W-1:0] acq_tads(input logic [2:0] sel);
        case (sel)
            3'b000:  acq_tads = 5'h00;
            3'b001:  acq_tads = 5'h02;
            3'b010:  acq_tads = 5'h04;
            3'b011:  acq_tads = 5'h06;
            3'b100:  acq_tads = 5'h08;
            3'b101:  acq_tads = 5'h0c;
            3'b110:  acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction

    wire rc_sel  = (ctrl2.clk_sel[1:0] == 2'b11);
    wire [PERIOD_W:0] period = period_of(ctrl2.clk_sel);
    wire [TAD_CNT_W-1:0] acq_len = acq_tads(ctrl2.acq_sel);

    // pins and rc clock resynchronised, change accepted once stages 2 and 3 agree
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rc_sync   <= 3'h0;
            rc_level  <= 1'b0;
            pin_s1    <= '0;
            pin_s2    <= '0;
            pin_s3    <= '0;
            pin_level <= '0;
        end
        else if (clk_en)
        begin
            rc_sync <= {rc_sync[1:0], internal_rc_conv_clk};
            if (rc_sync[2] == rc_sync[1])
                rc_level <= rc_sync[2];
            pin_s1 <= port_pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int i = 0; i < NUM_AN; i++)
                if (pin_s3[i] == pin_s2[i])
                    pin_level[i] <= pin_s3[i];
        end
    end

    // conversion clock tick: divided oscillator or rising edge of rc level
    logic rc_prev;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            div_cnt <= '0;
            rc_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            rc_prev <= rc_level;
            if (state == ST_SAMPLE || state == ST_SLEEP || div_cnt >= period[PERIOD_W-1:0] - 6'h01)
                div_cnt <= '0;
            else
                div_cnt <= div_cnt + 6'h01;
        end
    end

    assign tad_tick = rc_sel ? (rc_level && !rc_prev)
                             : (div_cnt >= period[PERIOD_W-1:0] - 6'h01);

    // axi write channel capture
    assign wr_fire = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
            wr_addr       <= '0;
            wr_data       <= '0;
            wr_strb       <= '0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                wr_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
                wr_strb <= s_axi_wstrb;
            end
            if (wr_fire)
            begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr[7:2] > ADDR_PORT_DATA[7:2]) ? 2'h2 : 2'h0;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    wire wr_ctrl0 = wr_fire && wr_addr[7:2] == ADDR_CTRL_ZERO[7:2] && wr_strb[0];
    assign go_wr_set = wr_ctrl0 && wr_data[GO_BIT] && ctrl0.enable;
    assign go_wr_clr = wr_ctrl0 && !wr_data[GO_BIT];

    // control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl0.channel <= '0;
            ctrl0.enable  <= 1'b0;
            ctrl2         <= '0;
            vref_cfg      <= '0;
            strap_taken   <= 1'b0;
            port_analog_cfg_field <= PORT_ANALOG_CFG_FIELD_RST_DIGITAL;
        end
        else if (clk_en)
        begin
            // strap caught on the first enabled cycle after release
            if (!strap_taken)
            begin
                strap_taken <= 1'b1;
                port_analog_cfg_field <= portb_analog_reset_cfg ? PORT_ANALOG_CFG_FIELD_RST_ANALOG
                                                                : PORT_ANALOG_CFG_FIELD_RST_DIGITAL;
            end
            else if (wr_fire && wr_addr[7:2] == ADDR_CTRL_ONE[7:2] && wr_strb[0])
            begin
                port_analog_cfg_field <= wr_data[PORT_ANALOG_CFG_FIELD_LSB +: PORT_ANALOG_CFG_FIELD_W];
                vref_cfg              <= wr_data[VCFG_LSB +: VCFG_W];
            end
            if (wr_ctrl0)
            begin
                ctrl0.enable  <= wr_data[EN_BIT];
                ctrl0.channel <= wr_data[CHS_LSB +: CHS_W];
            end
            if (wr_fire && wr_addr[7:2] == ADDR_CTRL_TWO[7:2] && wr_strb[0])
            begin
                ctrl2.acq_sel    <= wr_data[ACQ_LSB +: ACQ_W];
                ctrl2.clk_sel    <= wr_data[CLK_LSB +: CLK_W];
                ctrl2.right_just <= wr_data[FMT_BIT];
            end
        end
    end

    // sequencer: go bit is the single busy indication across acquire and convert
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state    <= ST_SAMPLE;
            ctrl0.go <= 1'b0;
            tad_cnt  <= '0;
            tcy_cnt  <= '0;
        end
        else if (clk_en)
        begin
            if (!ctrl0.enable)
            begin
                state    <= ST_SAMPLE;
                ctrl0.go <= 1'b0;
            end
            else
            begin
                case (state)
                    ST_SAMPLE:
                    begin
                        tad_cnt <= '0;
                        tcy_cnt <= '0;
                        if (go_wr_set)
                        begin
                            ctrl0.go <= 1'b1;
                            if (acq_len != '0)
                                state <= ST_ACQ;
                            else if (rc_sel)
                                state <= ST_SLEEP;
                            else
                                state <= ST_CONVERT;
                        end
                    end
                    ST_SLEEP:
                    begin
                        tcy_cnt <= tcy_cnt + 3'h1;
                        if (go_wr_clr)
                        begin
                            ctrl0.go <= 1'b0;
                            state    <= ST_SAMPLE;
                        end
                        else if (tcy_cnt == TCY_CLKS - 3'h1)
                            state <= ST_CONVERT;
                    end
                    ST_ACQ:
                    begin
                        if (go_wr_clr)
                        begin
                            ctrl0.go <= 1'b0;
                            state    <= ST_SAMPLE;
                        end
                        else if (tad_tick)
                        begin
                            if (tad_cnt == acq_len - 5'h01)
                            begin
                                tad_cnt <= '0;
                                state   <= ST_CONVERT;
                            end
                            else
                                tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                    ST_CONVERT:
                    begin
                        if (go_wr_clr)
                        begin
                            ctrl0.go <= 1'b0;
                            tad_cnt  <= '0;
                            state    <= ST_RECOVER;
                        end
                        else if (tad_tick)
                        begin
                            if (tad_cnt == CONV_TADS - 5'h01)
                            begin
                                ctrl0.go <= 1'b0;
                                tad_cnt  <= '0;
                                state    <= ST_RECOVER;
                            end
                            else
                                tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                    ST_RECOVER:
                    begin
                        if (tad_tick)
                        begin
                            if (tad_cnt == RECOVER_TADS - 5'h01)
                                state <= ST_SAMPLE;
                            else
                                tad_cnt <= tad_cnt + 5'h01;
                        end
                    end
                    default:
                    begin
                        state    <= ST_SAMPLE;
                        ctrl0.go <= 1'b0;
                    end
                endcase
            end
        end
    end

    wire conv_finish = ctrl0.enable && state == ST_CONVERT && !go_wr_clr && tad_tick
                       && tad_cnt == CONV_TADS - 5'h01;

    // result pair and done flag; hardware set wins over software clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            conv_done_irq_flag <= 1'b0;
        else if (clk_en)
        begin
            if (conv_finish)
                conv_done_irq_flag <= 1'b1;
            else if (wr_fire && wr_addr[7:2] == ADDR_STATUS[7:2] && wr_strb[0]
                     && wr_data[DONE_BIT])
                conv_done_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            result_pair <= '0;
        else if (clk_en)
        begin
            if (conv_finish)
                result_pair <= sar_bit_result;
            else if (wr_fire && wr_addr[7:2] == ADDR_RESULT[7:2] && wr_strb[0])
                result_pair <= wr_data[RES_W-1:0];
        end
    end

    // front end drive: sampling stops the moment conversion begins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            front                  <= '0;
            hold_capacitor_connect <= 1'b0;
        end
        else if (clk_en)
        begin
            front.channel   <= ctrl0.channel;
            front.convert   <= (state == ST_CONVERT);
            front.sample_en <= ctrl0.enable && state != ST_CONVERT
                               && state != ST_RECOVER;
            hold_capacitor_connect <= ctrl0.enable && state != ST_CONVERT
                                      && state != ST_RECOVER;
        end
    end

    // analog pins: configuration code n leaves channels below 15-n analog
    generate
        for (genvar g = 0; g < NUM_AN; g++)
        begin : gen_mask
            assign analog_mask[g] = (port_analog_cfg_field == 4'h0)
                || (5'(g) + 5'(port_analog_cfg_field) < 5'h0f);
        end
    endgenerate

    // axi read
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= 2'h0;
        end
        else if (clk_en)
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr[7:2])
                    ADDR_CTRL_ZERO[7:2]: s_axi_rdata <= 32'(ctrl0.channel) << CHS_LSB
                        | 32'(ctrl0.go) << GO_BIT | 32'(ctrl0.enable);
                    ADDR_CTRL_ONE[7:2]:  s_axi_rdata <= 32'(vref_cfg) << VCFG_LSB
                        | 32'(port_analog_cfg_field);
                    ADDR_CTRL_TWO[7:2]:  s_axi_rdata <= 32'(ctrl2.right_just) << FMT_BIT
                        | 32'(ctrl2.acq_sel) << ACQ_LSB | 32'(ctrl2.clk_sel);
                    ADDR_RESULT[7:2]:    s_axi_rdata <= 32'(result_pair);
                    ADDR_STATUS[7:2]:    s_axi_rdata <= 32'(conv_done_irq_flag);
                    ADDR_PORT_DATA[7:2]: s_axi_rdata <= 32'(pin_level & ~analog_mask);
                    default:
                    begin
                        s_axi_rdata <= '0;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// [hdl/adcs_pkg.sv]
package adcs_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL_ZERO  = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h04;
    localparam logic [7:0] ADDR_CTRL_TWO   = 8'h08;
    localparam logic [7:0] ADDR_RESULT     = 8'h0c;
    localparam logic [7:0] ADDR_STATUS     = 8'h10;
    localparam logic [7:0] ADDR_PORT_DATA  = 8'h14;

    // control zero fields
    localparam int EN_BIT   = 0;
    localparam int GO_BIT   = 1;
    localparam int CHS_LSB  = 2;
    localparam int CHS_W    = 4;
    // control one fields
    localparam int PORT_ANALOG_CFG_FIELD_LSB = 0;
    localparam int PORT_ANALOG_CFG_FIELD_W   = 4;
    localparam int VCFG_LSB = 4;
    localparam int VCFG_W   = 2;
    // control two fields
    localparam int CLK_LSB  = 0;
    localparam int CLK_W    = 3;
    localparam int ACQ_LSB  = 3;
    localparam int ACQ_W    = 3;
    localparam int FMT_BIT  = 7;
    // status fields
    localparam int DONE_BIT = 0;

    localparam int RES_W     = 10;
    localparam int NUM_AN    = 11;
    localparam int PERIOD_W  = 6;
    localparam int TAD_CNT_W = 5;

    localparam logic [PORT_ANALOG_CFG_FIELD_W-1:0] PORT_ANALOG_CFG_FIELD_RST_ANALOG  = 4'h0;
    localparam logic [PORT_ANALOG_CFG_FIELD_W-1:0] PORT_ANALOG_CFG_FIELD_RST_DIGITAL = 4'h7;

    localparam logic [TAD_CNT_W-1:0] CONV_TADS    = 5'h0b;
    localparam logic [TAD_CNT_W-1:0] RECOVER_TADS = 5'h02;

    // instruction cycle is four oscillator periods
    localparam logic [2:0] TCY_CLKS = 3'h4;

    typedef enum logic [2:0] {
        ST_SAMPLE  = 3'b000,
        ST_SLEEP   = 3'b001,
        ST_ACQ     = 3'b010,
        ST_CONVERT = 3'b011,
        ST_RECOVER = 3'b100
    } adcs_state_e;

    typedef struct packed {
        logic [CHS_W-1:0]  channel;
        logic              go;
        logic              enable;
    } adcs_ctrl0_s;

    typedef struct packed {
        logic [2:0]  acq_sel;
        logic [2:0]  clk_sel;
        logic        right_just;
    } adcs_ctrl2_s;

    typedef struct packed {
        logic              sample_en;
        logic              convert;
        logic [CHS_W-1:0]  channel;
    } adcs_front_s;

endpackage

// [sim/adcs_seq_asserts.sv]
module adcs_seq_asserts
    import adcs_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // front end
    input wire adcs_front_s front,
    input wire logic        hold_capacitor_connect,
    input wire logic        conv_done_irq_flag,
    // bus read
    input wire logic        s_axi_rvalid,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [31:0] s_axi_rdata
);
    logic [15:0] conv_cnt;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // cycles spent in the current conversion
    always_ff @(posedge aclk)
        conv_cnt <= front.convert ? conv_cnt + 16'h1 : 16'h0;

    cap_off_a: assert property (front.convert |-> !hold_capacitor_connect)
        else $error("holding capacitor connected in conversion");
    cap_on_a: assert property (front.sample_en |-> hold_capacitor_connect)
        else $error("sampling without holding capacitor");
    reset_off_a: assert property ($rose(aresetn) |-> !front.convert && !conv_done_irq_flag)
        else $error("converter active right after reset");
    conv_min_a: assert property ($rose(conv_done_irq_flag) |-> conv_cnt >= 16'd21)
        else $error("conversion shorter than eleven periods");
    conv_max_a: assert property (front.convert |-> conv_cnt <= 16'd720)
        else $error("conversion longer than eleven slowest periods");
    flag_end_a: assert property ($rose(conv_done_irq_flag) |-> ##1 $fell(front.convert))
        else $error("done flag not tied to conversion end");
    recover_a: assert property ($fell(front.convert) |-> !front.sample_en [*4])
        else $error("sampling resumed before two periods");
    resume_a: assert property ($fell(front.convert) |-> ##[4:200] front.sample_en)
        else $error("sampling not resumed after recovery");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0)
        else $error("error read returned data");

    cover property ($rose(conv_done_irq_flag));
    cover property ($fell(front.convert) && !$rose(conv_done_irq_flag));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule

bind adcs_sequencer adcs_seq_asserts u_chk (.aclk, .aresetn, .front, .hold_capacitor_connect,
    .conv_done_irq_flag, .s_axi_rvalid, .s_axi_rresp, .s_axi_rdata);

// [sim/adcs_front_model.sv]
module adcs_front_model
    import adcs_pkg::*;
(
    // from sequencer
    input wire adcs_front_s    front,
    // to sequencer
    output logic [RES_W-1:0]   sar_bit_result,
    output logic [NUM_AN-1:0]  port_pins,
    output logic               internal_rc_conv_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [RES_W-1:0] code;

    assign code = {front.channel, 6'h2a};
    // result only meaningful while converting, scrambled otherwise
    assign sar_bit_result = front.convert ? code : ~code;
    assign port_pins = '1;

    // rc oscillator free-running, unrelated to aclk
    initial
    begin
        internal_rc_conv_clk = 1'b0;
        forever #77 internal_rc_conv_clk = ~internal_rc_conv_clk;
    end
endmodule

// [sim/adcs_acq_conversion_sequencer_tb.sv]
module adc_acq_conversion_sequencer_tb import adcs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk, aresetn, clk_en, portb_analog_reset_cfg, internal_rc_conv_clk;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic hold_capacitor_connect, conv_done_irq_flag;
    logic [7:0]        s_axi_awaddr, s_axi_araddr;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [3:0]        s_axi_wstrb;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic [RES_W-1:0]  sar_bit_result;
    logic [NUM_AN-1:0] port_pins;
    adcs_front_s       front;
    int num_errors, total_checks, cyc, na, nc;
    int per[8] = '{2, 8, 32, 0, 4, 16, 64, 0};
    int acqt[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

    adcs_sequencer dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .portb_analog_reset_cfg,
        .internal_rc_conv_clk, .sar_bit_result, .port_pins, .front, .hold_capacitor_connect,
        .conv_done_irq_flag);
    adcs_front_model u_afe (.front, .sar_bit_result, .port_pins, .internal_rc_conv_clk);

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // acquisition gap and conversion length of the latest start
    always @(posedge aclk)
    begin
        cyc++;
        if (front.convert === 1'b1)
            nc++;
        else if (nc == 0)
            na++;
        if (cyc == 60000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        total_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(re));
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic do_reset(input logic strap);
        portb_analog_reset_cfg <= strap;
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
    endtask

    task automatic conv(input logic [2:0] acq, input logic [2:0] clk, input logic [3:0] ch);
        wr(ADDR_STATUS, 32'h1);
        wr(ADDR_CTRL_TWO, {26'h0, acq, clk});
        wr(ADDR_CTRL_ZERO, {26'h0, ch, 2'b01});
        repeat (20) @(posedge aclk);
        na = 0;
        nc = 0;
        wr(ADDR_CTRL_ZERO, {26'h0, ch, 2'b11});
        while (conv_done_irq_flag !== 1'b1)
            @(posedge aclk);
    endtask

    initial
    begin
        logic [31:0] e;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        clk_en = 1'b1;
        portb_analog_reset_cfg = 1'b1;
        do_reset(1'b1);
        rchk(ADDR_CTRL_ONE, 32'h0, 2'h0);
        rchk(ADDR_CTRL_ZERO, 32'h0, 2'h0);
        rchk(8'h18, 32'h0, 2'h2);
        for (int i = 0; i < 8; i++)
        begin
            conv(i[2:0], i[2:0], i[3:0]);
            if (per[i] == 0)
                chk_rng(nc, 70, 95);
            else
            begin
                chk_rng(na, acqt[i] * per[i], (acqt[i] + 1) * per[i] + 6);
                chk_rng(nc, 11 * per[i] - 2, 11 * per[i] + 2);
            end
            rchk(ADDR_RESULT, {22'h0, i[3:0], 6'h2a}, 2'h0);
            rchk(ADDR_CTRL_ZERO, {26'h0, i[3:0], 2'b01}, 2'h0);
            repeat (200) @(posedge aclk);
        end
        conv(3'h0, 3'h3, 4'h5);
        chk_rng(na, 4, 30);
        wr(ADDR_STATUS, 32'h1);
        wr(ADDR_RESULT, 32'h155);
        wr(ADDR_CTRL_TWO, 32'h6);
        wr(ADDR_CTRL_ZERO, 32'h3);
        repeat (100) @(posedge aclk);
        wr(ADDR_CTRL_ZERO, 32'h1);
        repeat (300) @(posedge aclk);
        rchk(ADDR_RESULT, 32'h155, 2'h0);
        rchk(ADDR_STATUS, 32'h0, 2'h0);
        for (int c = 0; c < 16; c++)
        begin
            wr(ADDR_CTRL_ONE, 32'(c));
            e = '0;
            for (int g = 0; g < NUM_AN; g++)
                e[g] = (c != 0) && (g + c >= 15);
            rchk(ADDR_PORT_DATA, e, 2'h0);
        end
        wr(ADDR_CTRL_ZERO, 32'h3);
        repeat (10) @(posedge aclk);
        do_reset(1'b0);
        rchk(ADDR_CTRL_ZERO, 32'h0, 2'h0);
        rchk(ADDR_CTRL_ONE, 32'h7, 2'h0);
        finish_test();
    end
endmodule
